// [core/irc_defs.vh]
// Purpose : Constants for the interrupt and reset control block
// Assumes : Included by core/irc_core.v only
// Notes   : Offsets are APB byte addresses, one 32-bit word per register
`ifndef IRC_DEFS_VH
`define IRC_DEFS_VH

// Register byte offsets
`define IRC_OFF_CTRL      8'h00
`define IRC_OFF_STATUS    8'h04
`define IRC_OFF_WDCLR     8'h08
`define IRC_OFF_WDTO      8'h0C

// Control register fields and reset value
`define IRC_CTRL_EDGE_ONLY 0
`define IRC_CTRL_WD_EN     1
`define IRC_CTRL_RST       2'h0

// Status register fields
`define IRC_ST_EXT        0
`define IRC_ST_TIMER      1
`define IRC_ST_SCI        2
`define IRC_ST_SPI        3
`define IRC_ST_WDF        4
`define IRC_ST_C12        5
`define IRC_ST_TRAP       6

// Vector addresses, high byte of each pair is the even address
`define IRC_VEC_RESET     16'h3FFE
`define IRC_VEC_TRAP      16'h3FFC
`define IRC_VEC_EXT       16'h3FFA
`define IRC_VEC_TIMER     16'h3FF8
`define IRC_VEC_SCI       16'h3FF6
`define IRC_VEC_SPI       16'h3FF4

// Watchdog service keys
`define IRC_WD_KEY1       8'h55
`define IRC_WD_KEY2       8'hAA

// Timing counts in processor clock cycles
`define IRC_STAB_CYC      13'h0FE0
`define IRC_PIN_PULSE     13'h0004
`define IRC_WDTO_RST      32'h00008000

// Stack bytes used by one interrupt entry
`define IRC_STACK_BYTES   3'h5

`endif

// [core/irc_core.v]
// Purpose : Interrupt priority, vectoring and reset sourcing
// Assumes : One 100 MHz clock; CPU pulses instr_done_i at each boundary
// Notes   : APB slave, one wait state on every access
// Function
// - Trap instruction taken despite global mask
// - Earlier-pending interrupts precede trap, later follow
// - Trap vector 3FFC, instruction-level priority
// - Any reset aborts and loads 3FFE vector
// - Priority reset, external, timer, async, sync
// - Global mask holds off all maskable interrupts
// - Falling edge latched, synchronised, vector 3FFA
// - Pulled-up port B pins act as requests
// - Line test branches see port B too
// - Sensitivity by option bit or mask bit
// - External latch cleared on entry start
// - Timer flags with enables, vector 3FF8
// - Five async serial flags, vector 3FF6
// - Sync serial flags with enable, 3FF4
// - Power-up holds reset 4064 cycles
// - Software mode drives pin low meanwhile
// - Stay in reset while pin low
// - Pin input-only in mask mode
// - Sequence starts first edge after pin high
// - Unserviced watchdog expiry resets device
// - Watchdog enable by bit or mask option
// - Check at boundary, external first
// - Entry pushes five bytes, sets mask
`timescale 1ns/100ps
`include "irc_defs.vh"

module irc_core #(
  parameter [31:0] WDTO_DEFAULT = `IRC_WDTO_RST  // Watchdog period, cycles
) (
  input  wire        clk_i,              // Processor clock
  input  wire        sys_rst_i,          // Synchronous reset, high
  input  wire        psel_i,             // APB select
  input  wire        penable_i,          // APB enable
  input  wire        pwrite_i,           // APB direction
  input  wire [7:0]  paddr_i,            // APB byte address
  input  wire [31:0] pwdata_i,           // APB write data
  output wire [31:0] prdata_o,           // APB read data
  output wire        pready_o,           // APB ready
  output wire        pslverr_o,          // APB error, unmapped address
  input  wire        mode_c12_i,         // Strap: mask-option mode
  input  wire        mask_edge_select_bit_i, // Strap: edge-only in mask mode
  input  wire        mask_watchdog_enable_i, // Strap: watchdog on in mask mode
  input  wire        power_up_i,         // Power-up detect, asynchronous
  input  wire        osc_active_i,       // Oscillator running, asynchronous
  input  wire        clk_monitor_fail_i, // Clock monitor alarm, asynchronous
  input  wire        rst_pin_i,          // Reset pin level
  output wire        rst_pin_o,          // Reset pin drive value
  output wire        rst_pin_oe_o,       // Reset pin drive enable
  input  wire        ext_req_n_i,        // External request pin
  input  wire [7:0]  portb_i,            // Port B pin levels
  input  wire [7:0]  portb_pullup_i,     // Port B pull-up enables
  input  wire [2:0]  timer_flags_i,      // Capture, compare, wrap flags
  input  wire [2:0]  timer_en_i,         // Matching enables
  input  wire [4:0]  sci_flags_i,        // Tx empty, tx done, rx full, ovr, idle
  input  wire [4:0]  sci_en_i,           // Matching enables
  input  wire [1:0]  spi_flags_i,        // Transfer done, mode fault
  input  wire        spi_en_i,           // Sync port interrupt enable
  input  wire        global_mask_i,      // Mask flag of condition codes
  input  wire        instr_done_i,       // Current instruction completes
  input  wire        trap_fetch_i,       // Trap instruction fetched
  input  wire        trap_exec_i,        // Boundary instruction is the trap
  output wire        sys_reset_o,        // Internal reset to CPU
  output wire        take_o,             // Entry or reset start, one pulse
  output wire [15:0] vector_o,           // Vector address for take_o
  output wire        set_mask_o,         // Set mask flag, one pulse
  output wire [2:0]  stack_bytes_o,      // Bytes to push on entry
  output wire        line_low_o          // Level for line test branches
);

  // Reset sequencer states, one-hot
  localparam [3:0] ST_RUN   = 4'h1;  // Normal operation
  localparam [3:0] ST_STAB  = 4'h2;  // Power-up stabilisation count
  localparam [3:0] ST_PULSE = 4'h4;  // Short drive after internal fault
  localparam [3:0] ST_HOLD  = 4'h8;  // Waiting for pin to rise

  // Maps hardware requests to a vector, highest-priority set request wins
  function [15:0] irc_vec;
    input [3:0] req;                 // Ext, timer, sci, spi
    begin
      if (req[0])
        irc_vec = `IRC_VEC_EXT;
      else if (req[1])
        irc_vec = `IRC_VEC_TIMER;
      else if (req[2])
        irc_vec = `IRC_VEC_SCI;
      else
        irc_vec = `IRC_VEC_SPI;
    end
  endfunction

  // Two-flop synchronisers
  reg  [11:0] s1_q;                  // First stage, read only by s2_q
  reg  [11:0] s2_q;                  // Second stage, safe to use
  wire        por_s   = s2_q[0];     // Power-up detect
  wire        osc_s   = s2_q[1];     // Oscillator active
  wire        cmf_s   = s2_q[2];     // Clock monitor alarm
  wire        pin_s   = s2_q[3];     // Reset pin level
  wire [7:0]  pb_s    = s2_q[11:4];  // Port B levels
  reg         ext_s1_q;              // External pin, first stage
  reg         ext_s_q;               // External pin, second stage

  // Pin levels arrive from outside the clock domain
  always @(posedge clk_i) begin
    s1_q     <= {portb_i, rst_pin_i, clk_monitor_fail_i, osc_active_i,
                 power_up_i};
    s2_q     <= s1_q;
    ext_s1_q <= ext_req_n_i;
    ext_s_q  <= ext_s1_q;
  end

  // Straps caught once after release, then frozen
  reg        strap_done_q;           // Straps taken
  reg        c12_q;                  // Mask-option mode
  reg        m_edge_q;               // Mask edge-only select
  reg        m_wd_q;                 // Mask watchdog enable
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      strap_done_q <= 1'b0;
      c12_q        <= 1'b0;
      m_edge_q     <= 1'b0;
      m_wd_q       <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      c12_q        <= mode_c12_i;
      m_edge_q     <= mask_edge_select_bit_i;
      m_wd_q       <= mask_watchdog_enable_i;
    end
  end

  // Software registers and bus answer
  reg  [1:0]  ctrl_q;                // Edge-only, watchdog enable
  reg  [31:0] wdto_q;                // Watchdog period
  reg  [31:0] wd_cnt_q;              // Watchdog count
  reg         wd_key_q;              // First service key seen
  reg         wdf_q;                 // Watchdog or monitor reset flag
  reg         pready_q;              // Access phase answered
  reg  [31:0] prdata_q;              // Read data
  reg         pslverr_q;             // Error answer
  reg         intr_q;                // Internal reset active
  reg  [3:0]  st_q;                  // Reset sequencer state
  reg  [12:0] cnt_q;                 // Sequencer counter
  reg         drive_q;               // Pin driven low
  reg         ext_latch_q;           // External edge latch
  reg         line_low_q;            // Combined line level, previous
  reg         trap_pend_q;           // Trap fetched, not yet taken
  reg  [3:0]  snap_q;                // Requests pending at trap fetch
  reg         take_q;                // Entry pulse
  reg  [15:0] vec_q;                 // Vector address
  reg         setm_q;                // Set mask pulse
  reg         rst_seen_q;            // Internal reset was active

  wire acc    = psel_i && penable_i && !pready_q;
  wire fin    = psel_i && penable_i && pready_q;
  wire wr_fin = fin && pwrite_i;
  wire rd_fin = fin && !pwrite_i;
  wire hit    = (paddr_i == `IRC_OFF_CTRL) || (paddr_i == `IRC_OFF_STATUS)
             || (paddr_i == `IRC_OFF_WDCLR) || (paddr_i == `IRC_OFF_WDTO);

  // Effective sensitivity and watchdog enable by mode
  wire edge_only = c12_q ? m_edge_q : ctrl_q[`IRC_CTRL_EDGE_ONLY];
  wire wd_on     = c12_q ? m_wd_q : ctrl_q[`IRC_CTRL_WD_EN];

  // Combined external line: request pin plus pulled-up port B pins
  wire line_low  = !ext_s_q || |(~pb_s & portb_pullup_i);
  wire ext_fall  = line_low && !line_low_q;
  wire ext_req   = ext_latch_q || (!edge_only && line_low);

  // Maskable requests by source
  wire [3:0] req;
  assign req[0] = ext_req;
  assign req[1] = |(timer_flags_i & timer_en_i);
  assign req[2] = |(sci_flags_i & sci_en_i);
  assign req[3] = |spi_flags_i && spi_en_i;

  // Only requests pending at trap fetch may precede the trap
  wire [3:0] elig    = trap_pend_q ? (req & snap_q) : req;
  wire       hw_go   = instr_done_i && !global_mask_i && |elig
                       && !intr_q;
  wire       trap_go = instr_done_i && trap_pend_q && !hw_go
                       && !intr_q;
  wire       ext_taken = hw_go && elig[0];

  // Watchdog service sequence and expiry
  wire wd_wr   = wr_fin && (paddr_i == `IRC_OFF_WDCLR);
  wire wd_svc  = wd_wr && (c12_q ? !pwdata_i[0]
                 : (wd_key_q && pwdata_i[7:0] == `IRC_WD_KEY2));
  wire wd_exp  = wd_on && (wd_cnt_q >= wdto_q) && !intr_q;

  // Bus slave: one wait state, writes at the final edge, read data captured one edge earlier
  always @(posedge clk_i) begin
    if (sys_rst_i || intr_q) begin
      ctrl_q   <= `IRC_CTRL_RST;
      wdto_q   <= WDTO_DEFAULT;
      wd_key_q <= 1'b0;
    end else begin
      if (wr_fin && paddr_i == `IRC_OFF_CTRL)
        ctrl_q <= pwdata_i[1:0];
      if (wr_fin && paddr_i == `IRC_OFF_WDTO)
        wdto_q <= pwdata_i;
      // First key arms, second key services in software mode; anything else disarms
      if (wd_wr)
        wd_key_q <= (pwdata_i[7:0] == `IRC_WD_KEY1);
    end
  end

  // Answer timing and read data
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc && !hit;
      if (acc && !pwrite_i) begin
        case (paddr_i)
          `IRC_OFF_CTRL:   prdata_q <= {30'h00000000, ctrl_q};
          `IRC_OFF_STATUS: prdata_q <= {25'h0000000, trap_pend_q, c12_q,
                                        wdf_q, req};
          `IRC_OFF_WDTO:   prdata_q <= wdto_q;
          default:         prdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  // Watchdog counter and sticky flag; the flag survives internal reset
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wd_cnt_q <= 32'h00000000;
      wdf_q    <= 1'b0;
    end else begin
      if (intr_q || wd_svc || !wd_on)
        wd_cnt_q <= 32'h00000000;
      else
        wd_cnt_q <= wd_cnt_q + 32'h00000001;
      // Set wins over the read-clear
      if (wd_exp || cmf_s)
        wdf_q <= 1'b1;
      else if (rd_fin && paddr_i == `IRC_OFF_STATUS)
        wdf_q <= 1'b0;
    end
  end

  // Reset sequencer: stabilisation, fault pulse, pin hold
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q    <= ST_STAB;
      cnt_q   <= `IRC_STAB_CYC;
      drive_q <= 1'b0;
      intr_q  <= 1'b1;
    end else if (por_s) begin
      // Power-up restarts the full delay
      st_q    <= ST_STAB;
      cnt_q   <= `IRC_STAB_CYC;
      drive_q <= !c12_q && strap_done_q;
      intr_q  <= 1'b1;
    end else begin
      case (st_q)
        ST_RUN: begin
          drive_q <= 1'b0;
          if (wd_exp || cmf_s) begin
            // Fault resets drive the pin only in software mode
            st_q    <= ST_PULSE;
            cnt_q   <= `IRC_PIN_PULSE;
            drive_q <= !c12_q;
            intr_q  <= 1'b1;
          end else if (!pin_s) begin
            st_q   <= ST_HOLD;
            intr_q <= 1'b1;
          end else
            intr_q <= 1'b0;
        end
        ST_STAB: begin
          intr_q  <= 1'b1;
          // Mode is unknown until the straps are taken, so no drive yet
          drive_q <= !c12_q && strap_done_q;
          // Counts only while the oscillator runs
          if (osc_s)
            cnt_q <= cnt_q - 13'h0001;
          if (osc_s && cnt_q == 13'h0001) begin
            st_q    <= ST_HOLD;
            drive_q <= 1'b0;
          end
        end
        ST_PULSE: begin
          intr_q <= 1'b1;
          cnt_q  <= cnt_q - 13'h0001;
          if (cnt_q == 13'h0001) begin
            st_q    <= ST_HOLD;
            drive_q <= 1'b0;
          end
        end
        ST_HOLD: begin
          intr_q  <= 1'b1;
          drive_q <= 1'b0;
          // Leaves on the first edge that sees the pin high
          if (pin_s) begin
            st_q   <= ST_RUN;
            intr_q <= 1'b0;
          end
        end
        default: begin
          st_q   <= ST_HOLD;
          intr_q <= 1'b1;
        end
      endcase
    end
  end

  // Interrupt entry, trap bookkeeping and external latch
  always @(posedge clk_i) begin
    if (sys_rst_i || intr_q) begin
      ext_latch_q <= 1'b0;
      line_low_q  <= 1'b0;
      trap_pend_q <= 1'b0;
      snap_q      <= 4'h0;
      take_q      <= 1'b0;
      setm_q      <= 1'b0;
      vec_q       <= `IRC_VEC_RESET;
      rst_seen_q  <= 1'b1;
    end else begin
      line_low_q <= line_low;
      // A new edge wins over the clear at entry
      if (ext_fall)
        ext_latch_q <= 1'b1;
      else if (ext_taken)
        ext_latch_q <= 1'b0;
      // Snapshot taken when the trap is fetched
      if (trap_fetch_i) begin
        trap_pend_q <= 1'b1;
        snap_q      <= req;
      end else if (trap_go)
        trap_pend_q <= 1'b0;
      rst_seen_q <= 1'b0;
      take_q     <= rst_seen_q || hw_go || trap_go;
      setm_q     <= hw_go || trap_go;
      if (rst_seen_q)
        vec_q <= `IRC_VEC_RESET;
      else if (hw_go)
        vec_q <= irc_vec(elig);
      else if (trap_go)
        vec_q <= `IRC_VEC_TRAP;
    end
  end

  // Line level for the branch-on-line tests
  reg line_low_o_q;                          // Registered line level
  always @(posedge clk_i) begin
    if (sys_rst_i)
      line_low_o_q <= 1'b0;
    else
      line_low_o_q <= line_low;
  end

  assign prdata_o      = prdata_q;
  assign pready_o      = pready_q;
  assign pslverr_o     = pslverr_q;
  assign rst_pin_o     = 1'b0;
  assign rst_pin_oe_o  = drive_q;
  assign sys_reset_o   = intr_q;
  assign take_o        = take_q;
  assign vector_o      = vec_q;
  assign set_mask_o    = setm_q;
  assign stack_bytes_o = `IRC_STACK_BYTES;
  assign line_low_o    = line_low_o_q;

endmodule // irc_core

// [verif/irc_core_asserts.sv]
// Purpose : Port-level checks for irc_core
// Assumes : Bound from the bench top, one clock domain
// Notes   : Every check is off while sys_rst_i is high
`timescale 1ns/100ps
module irc_core_asserts (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        mode_c12_i,
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_o,
  input wire logic        rst_pin_oe_o,
  input wire logic        global_mask_i,
  input wire logic        instr_done_i,
  input wire logic        sys_reset_o,
  input wire logic        take_o,
  input wire logic [15:0] vector_o,
  input wire logic        set_mask_o,
  input wire logic [2:0]  stack_bytes_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Entry to a maskable handler; trap and reset vectors lie outside
  wire hw_take  = take_o && vector_o >= 16'h3FF4 && vector_o <= 16'h3FFA;
  // Any entry except the start after reset
  wire ent_take = take_o && vector_o != 16'h3FFE;

  a_mask_holds: assert property (hw_take |-> !$past(global_mask_i))
    else $error("maskable entry taken under mask");
  a_take_boundary: assert property (ent_take |-> $past(instr_done_i))
    else $error("entry not at an instruction boundary");
  a_entry_masks: assert property (set_mask_o == ent_take)
    else $error("mask pulse does not match entry");
  a_stack_five: assert property (stack_bytes_o == 3'h5)
    else $error("stack byte count wrong");
  a_reset_vector: assert property ($fell(sys_reset_o) |->
    ##[0:2] (take_o && vector_o == 16'h3FFE))
    else $error("no reset vector after reset end");
  a_drive_low: assert property (rst_pin_oe_o |->
    !rst_pin_o ##[0:2] sys_reset_o)
    else $error("pin drive outside reset");
  a_mask_input: assert property (mode_c12_i && $past(mode_c12_i) |->
    !rst_pin_oe_o)
    else $error("pin driven in mask mode");
  a_pin_holds: assert property (!rst_pin_i [*6] |-> sys_reset_o)
    else $error("low reset pin did not hold reset");
  a_ready_next: assert property (psel_i && penable_i && !pready_o |=>
    pready_o)
    else $error("access not answered next cycle");
  a_ready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
endmodule // irc_core_asserts

// [verif/irc_cpu_model.sv]
// Purpose : Behavioural CPU core facing the interrupt block
// Assumes : Instruction boundary every fourth cycle outside reset
// Notes   : Unmask only on request, so pending sources pile up first
`timescale 1ns/100ps
module irc_cpu_model (
  input  wire logic clk_i,         // Processor clock
  input  wire logic cpu_reset_i,   // Core held in reset
  input  wire logic set_mask_i,    // Entry pulse from the block
  input  wire logic mask_clear_i,  // Bench asks the core to unmask
  output logic      instr_done_o,  // Boundary pulse
  output logic      global_mask_o  // Mask flag of the condition codes
);
  logic [1:0] phase_q;  // Boundary phase counter
  // Reset sets the mask so no maskable entry runs before software allows
  always @(posedge clk_i) begin
    if (cpu_reset_i) begin
      phase_q       <= 2'h0;
      global_mask_o <= 1'b1;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (set_mask_i) begin  // Entry wins over a clear request
        global_mask_o <= 1'b1;
      end else if (mask_clear_i) begin
        global_mask_o <= 1'b0;
      end
    end
  end
  // One-cycle boundary pulse, never while the core is in reset
  assign instr_done_o = (phase_q == 2'h3) && !cpu_reset_i;
endmodule // irc_cpu_model

// [verif/interrupt_and_reset_control_test.sv]
// Purpose : Self-checking bench for irc_core
// Assumes : 100 MHz clock, watchdog period shortened to 64 cycles
// Notes   : Expected vectors come from a priority model of the sources
`timescale 1ns/100ps
module interrupt_and_reset_control_test;
  logic        clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, mode_c12_i;
  logic        power_up_i, ext_req_n_i, trap_fetch_i, spi_en_i, mask_clear;
  logic        pin_pull, osc_active_i, clk_monitor_fail_i, trap_exec_i;
  logic        mask_edge_select_bit_i, mask_watchdog_enable_i, er, ext;
  logic [7:0]  paddr_i, portb_i, portb_pullup_i;
  logic [31:0] pwdata_i, rd, rnd, k;
  logic [2:0]  timer_flags_i, timer_en_i;
  logic [4:0]  sci_flags_i, sci_en_i;
  logic [3:0]  src;
  logic [1:0]  spi_flags_i;
  wire  [31:0] prdata_o;
  wire  [15:0] vector_o;
  wire  [2:0]  stack_bytes_o;
  wire         pready_o, pslverr_o, rst_pin_i, rst_pin_o, rst_pin_oe_o;
  wire         instr_done_i, global_mask_i, sys_reset_o, take_o, set_mask_o;
  wire         line_low_o;
  int          err_count, total_checks, seed, n, exp_v, drive_cnt;

  // Pin has a pull-up; device or outside logic may pull it low
  assign rst_pin_i = !(rst_pin_oe_o && !rst_pin_o) && !pin_pull;

  irc_core #(.WDTO_DEFAULT(32'h40)) dut (.clk_i, .sys_rst_i, .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o,
    .pslverr_o, .mode_c12_i, .mask_edge_select_bit_i,
    .mask_watchdog_enable_i, .power_up_i, .osc_active_i,
    .clk_monitor_fail_i, .rst_pin_i, .rst_pin_o, .rst_pin_oe_o,
    .ext_req_n_i, .portb_i, .portb_pullup_i, .timer_flags_i, .timer_en_i,
    .sci_flags_i, .sci_en_i, .spi_flags_i, .spi_en_i, .global_mask_i,
    .instr_done_i, .trap_fetch_i, .trap_exec_i, .sys_reset_o, .take_o,
    .vector_o, .set_mask_o, .stack_bytes_o, .line_low_o);
  irc_cpu_model cpu (.clk_i, .cpu_reset_i(sys_reset_o),
    .set_mask_i(set_mask_o), .mask_clear_i(mask_clear),
    .instr_done_o(instr_done_i), .global_mask_o(global_mask_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Cycles in which the device pulls the reset pin
  always @(posedge clk_i) if (rst_pin_oe_o === 1'b1) drive_cnt++;

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // APB transfer; the request stands until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // First vector taken within 40 edges, 0 if none; then stop unmasking
  task automatic wait_take();
    k = 0;
    for (n = 0; n < 40 && k == 0; n++) begin
      @(posedge clk_i);
      if (take_o === 1'b1) k = vector_o;
    end
    mask_clear <= 1'b0;
  endtask
  task automatic wait_release();
    for (n = 0; n < 6000 && sys_reset_o !== 1'b0; n++) @(posedge clk_i);
  endtask
  task automatic trap();
    @(posedge clk_i);
    trap_fetch_i <= 1'b1;
    @(posedge clk_i);
    trap_fetch_i <= 1'b0;
    wait_take();
    check(k, 32'h3FFC);
  endtask
  task automatic do_reset(input logic mode);
    @(posedge clk_i);
    mode_c12_i <= mode;
    sys_rst_i  <= 1'b1;
    repeat (6) @(posedge clk_i);
    sys_rst_i  <= 1'b0;
    wait_release();
  endtask
  task automatic print_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    seed = 73;
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {mode_c12_i, power_up_i, trap_fetch_i, mask_clear, pin_pull} = '0;
    {timer_flags_i, timer_en_i, sci_flags_i, sci_en_i} = '0;
    {spi_flags_i, spi_en_i, portb_pullup_i, clk_monitor_fail_i} = '0;
    {mask_edge_select_bit_i, mask_watchdog_enable_i, trap_exec_i} = '0;
    {ext_req_n_i, osc_active_i, sys_rst_i} = 3'h7;
    portb_i = 8'hFF;
    do_reset(1'b0);
    // Power-up with outside logic keeping the pin low past the delay
    drive_cnt = 0;
    power_up_i <= 1'b1;
    @(posedge clk_i);
    power_up_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    pin_pull <= 1'b1;
    for (n = 0; n < 6000 && !(drive_cnt > 0 && !rst_pin_oe_o); n++)
      @(posedge clk_i);
    check(drive_cnt >= 4064 && drive_cnt <= 4068, 1);
    repeat (20) @(posedge clk_i);
    check(sys_reset_o, 1);
    pin_pull <= 1'b0;
    wait_release();
    check(n <= 6, 1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[5], 0);
    apb(1'b1, 8'h00, 32'hFFFFFFFD);
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    trap();
    // Random sources, pending under mask, then released
    for (int it = 0; it < 24; it++) begin
      if (it == 12) apb(1'b1, 8'h00, 32'h0);
      rnd = $random(seed);
      src = rnd[31:28];
      @(posedge clk_i);
      timer_flags_i  <= rnd[2:0];
      timer_en_i     <= it[0] ? rnd[5:3] : 3'h0;
      sci_flags_i    <= rnd[10:6];
      sci_en_i       <= it[1] ? rnd[15:11] : 5'h0;
      spi_flags_i    <= rnd[17:16];
      spi_en_i       <= it[2] & rnd[18];
      portb_pullup_i <= rnd[26:19];
      if (src == 4'h8) ext_req_n_i <= 1'b0;
      if (src < 4'h8) portb_i[src[2:0]] <= 1'b0;
      ext = src == 4'h8 || (src < 4'h8 && rnd[19 + src]);
      if (ext) exp_v = 'h3FFA;
      else if (|(rnd[2:0] & rnd[5:3]) && it[0]) exp_v = 'h3FF8;
      else if (|(rnd[10:6] & rnd[15:11]) && it[1]) exp_v = 'h3FF6;
      else if (|rnd[17:16] && rnd[18] && it[2]) exp_v = 'h3FF4;
      else exp_v = 0;
      repeat (5) @(posedge clk_i);
      check(line_low_o, ext);
      ext_req_n_i <= 1'b1;
      portb_i     <= 8'hFF;
      repeat (4) @(posedge clk_i);
      mask_clear <= 1'b1;
      wait_take();
      check(k, exp_v);
      {timer_flags_i, sci_flags_i, spi_flags_i} <= '0;
      if (exp_v == 0) trap();
    end
    // Serviced watchdog stays quiet, neglected one resets
    apb(1'b1, 8'h00, 32'h2);
    repeat (6) begin
      repeat (30) @(posedge clk_i);
      apb(1'b1, 8'h08, 32'h55);
      apb(1'b1, 8'h08, 32'hAA);
    end
    check(sys_reset_o, 0);
    drive_cnt = 0;
    for (n = 0; n < 300 && sys_reset_o !== 1'b1; n++) @(posedge clk_i);
    check(sys_reset_o, 1);
    wait_release();
    check(drive_cnt, 4);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[4], 1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[4], 0);
    // Clock monitor alarm resets like the watchdog and sets the flag
    drive_cnt = 0;
    clk_monitor_fail_i <= 1'b1;
    @(posedge clk_i);
    clk_monitor_fail_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check(sys_reset_o, 1);
    wait_release();
    check(drive_cnt, 4);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[4], 1);
    // Mask-option mode leaves the pin as an input
    drive_cnt = 0;
    do_reset(1'b1);
    check(drive_cnt, 0);
    apb(1'b0, 8'h04, 32'h0);
    check(rd[5], 1);
    print_verdict();
  end

  // Hang guard, about three times the expected run
  initial begin
    repeat (40000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
endmodule // interrupt_and_reset_control_test

bind irc_core irc_core_asserts u_chk (.clk_i, .sys_rst_i, .psel_i,
  .penable_i, .pready_o, .pslverr_o, .mode_c12_i, .rst_pin_i, .rst_pin_o,
  .rst_pin_oe_o, .global_mask_i, .instr_done_i, .sys_reset_o, .take_o,
  .vector_o, .set_mask_o, .stack_bytes_o);
